// file: src/adc_conversion_control.v
// Conversion control, status registers and result capture of the ADC
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "adc_ctrl_defines.vh"
module adc_conversion_control (
  input wire clk,
  input wire reset,
  input wire [2:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regRdata,
  input wire hw_trigger_in,
  output reg convStart,
  output reg [4:0] convChannel,
  output reg convAbort,
  output reg converterOn,
  output reg inputIsolate,
  output reg tenBitMode,
  input wire coreDone,
  input wire [9:0] coreResult,
  output reg doneIrq
);

  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_START = 2'h2;

  ////////////////////////////////////////////////////////////////////
  // Register state
  reg conv_done_flag_q;
  reg done_irq_enable_q;
  reg continuous_enable_q;
  reg [4:0] channel_select_q;
  reg trigger_source_select_q;
  reg compare_enable_q;
  reg compare_ge_select_q;
  reg [1:0] lowCtrlTwo_q;
  reg [9:0] result_q;
  reg [9:0] compareValue_q;
  reg [7:0] config_q;
  reg conv_active_q;
  reg [1:0] state_q;
  reg trigPrev_q;
  reg highReadLock_q;

  wire trigSync;
  wire trigRise;
  wire compareHit;
  wire writeOne;
  wire readLow;
  wire readHigh;
  wire chanOff;
  wire doneTakes;
  wire doneSets;
  wire swStart;
  wire hwStart;
  wire again;
  wire tenBit;
  reg doneFlag_d;
  reg irqEnableNow;
  reg doneIrq_d;
  reg highReadLock_d;
  reg [9:0] result_d;

  adc_sync3 trigSyncInst (
    .clk(clk),
    .reset(reset),
    .din(hw_trigger_in),
    .dout(trigSync)
  );

  adc_compare cmpInst (
    .result(coreResult),
    .compareValue(compareValue_q),
    .tenBit(config_q[`BIT_MODE_TEN]),
    .geSelect(compare_ge_select_q),
    .hit(compareHit)
  );

  assign trigRise = trigSync & ~trigPrev_q;
  assign writeOne = regWrite & (regAddr == `ADDR_CTRL_ONE);
  assign readLow = regRead & (regAddr == `ADDR_RESULT_LOW);
  assign readHigh = regRead & (regAddr == `ADDR_RESULT_HIGH);
  assign chanOff = channel_select_q == `CHANNEL_OFF;
  // Done only counts while a conversion is really running
  assign doneTakes = coreDone & conv_active_q & ~writeOne;
  assign doneSets = doneTakes & (~compare_enable_q | compareHit);
  // Software start: the write itself, unless channel is all ones
  assign swStart = writeOne & ~trigger_source_select_q &
    (regWdata[4:0] != `CHANNEL_OFF);
  // Hardware start: wakeup counter overflow edge, only while no conversion is active
  assign hwStart = trigRise & trigger_source_select_q & ~chanOff &
    ~conv_active_q;
  assign again = continuous_enable_q & ~chanOff;
  assign tenBit = config_q[`BIT_MODE_TEN];

  ////////////////////////////////////////////////////////////////////
  // Next values of flag, interrupt, lock and results
  always @* begin
    doneFlag_d = conv_done_flag_q;
    if (doneSets) begin
      doneFlag_d = 1'b1;
    end else if (writeOne | readLow) begin
      doneFlag_d = 1'b0;
    end
  end

  // Enable as it stands once this cycle's write lands
  always @* begin
    irqEnableNow = done_irq_enable_q;
    if (writeOne) begin
      irqEnableNow = regWdata[`BIT_IRQ_ENABLE];
    end
    doneIrq_d = doneFlag_d & irqEnableNow;
  end

  // Reading high in 10-bit mode freezes results until low read
  always @* begin
    highReadLock_d = highReadLock_q;
    if (readHigh & tenBit) begin
      highReadLock_d = 1'b1;
    end else if (readLow) begin
      highReadLock_d = 1'b0;
    end
  end

  // A result arriving while locked is lost; software must read low
  always @* begin
    result_d = result_q;
    if (doneSets & ~(highReadLock_q & tenBit)) begin
      if (tenBit) begin
        result_d = coreResult;
      end else begin
        result_d = {2'h0, coreResult[7:0]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register writes
  always @(posedge clk) begin
    if (reset) begin
      done_irq_enable_q <= 1'b0;
      continuous_enable_q <= 1'b0;
      channel_select_q <= `RESET_CHANNEL;
      trigger_source_select_q <= 1'b0;
      compare_enable_q <= 1'b0;
      compare_ge_select_q <= 1'b0;
      lowCtrlTwo_q <= 2'h0;
      compareValue_q <= 10'h000;
      config_q <= `RESET_CONFIG;
    end else if (regWrite) begin
      case (regAddr)
        `ADDR_CTRL_ONE: begin
          done_irq_enable_q <= regWdata[`BIT_IRQ_ENABLE];
          continuous_enable_q <= regWdata[`BIT_CONTINUOUS];
          channel_select_q <= regWdata[4:0];
        end
        `ADDR_CTRL_TWO: begin
          trigger_source_select_q <= regWdata[`BIT_TRIG_SELECT];
          compare_enable_q <= regWdata[`BIT_COMPARE_EN];
          compare_ge_select_q <= regWdata[`BIT_COMPARE_GE];
          // Kept as written; software is to write zeros here
          lowCtrlTwo_q <= regWdata[1:0];
        end
        `ADDR_COMPARE_HIGH: compareValue_q[9:8] <= regWdata[1:0];
        `ADDR_COMPARE_LOW: compareValue_q[7:0] <= regWdata;
        `ADDR_CONFIG: config_q <= regWdata;
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Done flag, interrupt, results
  always @(posedge clk) begin
    if (reset) begin
      conv_done_flag_q <= 1'b0;
      doneIrq <= 1'b0;
      result_q <= 10'h000;
      highReadLock_q <= 1'b0;
      trigPrev_q <= 1'b0;
    end else begin
      trigPrev_q <= trigSync;
      conv_done_flag_q <= doneFlag_d;
      doneIrq <= doneIrq_d;
      highReadLock_q <= highReadLock_d;
      result_q <= result_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Conversion sequencer
  always @(posedge clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      conv_active_q <= 1'b0;
      convStart <= 1'b0;
      convAbort <= 1'b0;
      convChannel <= `RESET_CHANNEL;
      converterOn <= 1'b0;
      inputIsolate <= 1'b1;
    end else begin
      convStart <= 1'b0;
      convAbort <= 1'b0;
      if (writeOne) begin
        convAbort <= conv_active_q;
        conv_active_q <= 1'b0;
        convChannel <= regWdata[4:0];
        if (swStart) begin
          convStart <= 1'b1;
          conv_active_q <= 1'b1;
          converterOn <= 1'b1;
          inputIsolate <= 1'b0;
          state_q <= ST_WAIT;
        end else begin
          converterOn <= 1'b0;
          inputIsolate <= regWdata[4:0] == `CHANNEL_OFF;
          state_q <= ST_IDLE;
        end
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (hwStart) begin
              convStart <= 1'b1;
              conv_active_q <= 1'b1;
              converterOn <= 1'b1;
              inputIsolate <= 1'b0;
              state_q <= ST_WAIT;
            end
          end
          ST_WAIT: begin
            if (doneTakes) begin
              conv_active_q <= 1'b0;
              if (again & ~trigger_source_select_q) begin
                state_q <= ST_START;
              end else if (again) begin
                // Hardware continuous: next run follows next trigger
                state_q <= ST_IDLE;
              end else begin
                converterOn <= 1'b0;
                state_q <= ST_IDLE;
              end
            end
          end
          ST_START: begin
            if (again) begin
              convStart <= 1'b1;
              conv_active_q <= 1'b1;
              state_q <= ST_WAIT;
            end else begin
              converterOn <= 1'b0;
              state_q <= ST_IDLE;
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register reads, data in the cycle after the strobe
  always @(posedge clk) begin
    if (reset) begin
      regRdata <= 8'h00;
      tenBitMode <= 1'b0;
    end else begin
      tenBitMode <= config_q[`BIT_MODE_TEN];
      regRdata <= 8'h00;
      if (regRead) begin
        case (regAddr)
          `ADDR_CTRL_ONE: regRdata <= {conv_done_flag_q,
            done_irq_enable_q, continuous_enable_q, channel_select_q};
          `ADDR_CTRL_TWO: regRdata <= {conv_active_q,
            trigger_source_select_q, compare_enable_q,
            compare_ge_select_q, 2'h0, lowCtrlTwo_q};
          `ADDR_RESULT_HIGH: regRdata <= {6'h00, result_q[9:8]};
          `ADDR_RESULT_LOW: regRdata <= result_q[7:0];
          `ADDR_COMPARE_HIGH: regRdata <= {6'h00, compareValue_q[9:8]};
          `ADDR_COMPARE_LOW: regRdata <= compareValue_q[7:0];
          `ADDR_CONFIG: regRdata <= config_q;
          default: regRdata <= 8'h00;
        endcase
      end
    end
  end
endmodule // adc_conversion_control

// file: src/adc_ctrl_defines.vh
// Register offsets, field positions, channel codes and reset values
// How it works
// - Compare off: every finish sets done flag
// - Compare on: flag set only on true compare
// - Control-one write or result-low read clears flag
// - Flag rising with irq enable raises interrupt
// - Single mode: one conversion per start event
// - Continuous mode: repeat after first start event; with hardware trigger each run waits for the next trigger edge
// - Five-bit channel field decodes inputs and references
// - All-ones channel powers converter down, isolates input
// - All-ones code ends continuous, no extra conversion
// - Single mode returns to idle after completion
// - Active bit set on start, cleared end/abort
// - Trigger select picks software or hardware start
// - Compare enable bit turns comparison on/off
// - Direction bit: ge when set, lt when clear
// - Control-one write aborts conversion; restarts it only with software trigger selected
// - Results update on completion unless compare false or locked by a 10-bit high read
// - Hardware mode starts on each wakeup overflow; edges during an active conversion are ignored
// - Eight-bit mode compares only low eight bits
`ifndef ADC_CTRL_DEFINES_VH
`define ADC_CTRL_DEFINES_VH
`define ADDR_CTRL_ONE 3'h0
`define ADDR_CTRL_TWO 3'h1
`define ADDR_RESULT_HIGH 3'h2
`define ADDR_RESULT_LOW 3'h3
`define ADDR_COMPARE_HIGH 3'h4
`define ADDR_COMPARE_LOW 3'h5
`define ADDR_CONFIG 3'h6
`define BIT_DONE_FLAG 7
`define BIT_IRQ_ENABLE 6
`define BIT_CONTINUOUS 5
`define BIT_ACTIVE 7
`define BIT_TRIG_SELECT 6
`define BIT_COMPARE_EN 5
`define BIT_COMPARE_GE 4
`define BIT_MODE_TEN 3
`define CHANNEL_OFF 5'h1f
`define CHANNEL_RESERVED 5'h1c
`define CHANNEL_LAST_INPUT 5'h1b
`define RESET_CHANNEL 5'h1f
`define RESET_CONFIG 8'h00
`endif

// file: src/adc_sync3.v
// Three-stage synchroniser with agreement filter for an outside level
`timescale 1ns/1ps
module adc_sync3 (
  input wire clk,
  input wire reset,
  input wire din,
  output reg dout
);
  reg s1Q;
  reg s2Q;
  reg s3Q;
  always @(posedge clk) begin
    if (reset) begin
      s1Q <= 1'b0;
      s2Q <= 1'b0;
      s3Q <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1Q <= din;
      s2Q <= s1Q;
      s3Q <= s2Q;
      // Change accepted only once two late stages agree
      if (s2Q == s3Q) begin
        dout <= s3Q;
      end
    end
  end
endmodule // adc_sync3

// file: src/adc_compare.v
// Result versus compare-value test in 8- or 10-bit mode
`timescale 1ns/1ps
module adc_compare (
  input wire [9:0] result,
  input wire [9:0] compareValue,
  input wire tenBit,
  input wire geSelect,
  output wire hit
);
  wire [9:0] resultEff;
  wire [9:0] valueEff;
  wire isLess;
  assign resultEff = tenBit ? result : {2'h0, result[7:0]};
  assign valueEff = tenBit ? compareValue : {2'h0, compareValue[7:0]};
  assign isLess = resultEff < valueEff;
  assign hit = geSelect ? ~isLess : isLess;
endmodule // adc_compare

// file: testbench/adc_core_model.sv
// Behavioural converter core answering start requests
`timescale 1ns/1ps
module adc_core_model (
  input wire clk,
  input wire convStart,
  input wire convAbort,
  input wire [9:0] sample,
  input wire [3:0] lat,
  output reg coreDone,
  output reg [9:0] coreResult
);
  integer cnt = 0;
  initial coreDone = 1'b0;
  initial coreResult = 10'h000;
  always @(posedge clk) begin
    if (convStart) cnt <= lat;
    else if (convAbort) cnt <= 0;
    else if (cnt > 0) cnt <= cnt - 1;
    coreDone <= cnt == 1 && !convStart && !convAbort;
    // Result is only valid beside done, so scramble it otherwise
    coreResult <= cnt == 1 ? sample : ~coreResult;
  end
endmodule // adc_core_model

// file: testbench/adc_conversion_control_properties.sv
// Port-level checks for the conversion control block
`timescale 1ns/1ps
module adc_conversion_control_properties (
  input wire clk,
  input wire reset,
  input wire [2:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWrite,
  input wire hw_trigger_in,
  input wire convStart,
  input wire [4:0] convChannel,
  input wire converterOn,
  input wire inputIsolate,
  input wire coreDone,
  input wire doneIrq
);
  reg [4:0] chan_q;
  reg cont_q, ien_q, hw_q, cmp_q, busy_q;
  wire wr1 = regWrite && regAddr == 3'h0;
  always @(posedge clk) begin
    if (reset) begin
      chan_q <= 5'h1f;
      {ien_q, cont_q, hw_q, cmp_q, busy_q} <= 5'h00;
    end else begin
      if (wr1) {ien_q, cont_q, chan_q} <= regWdata[6:0];
      if (regWrite && regAddr == 3'h1) {hw_q, cmp_q} <= regWdata[6:5];
      busy_q <= convStart || (busy_q && !coreDone && !wr1);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // A write right after done cancels the restart
  sequence s_cont_done;
    coreDone && busy_q && cont_q && !hw_q && !wr1 && chan_q != 5'h1f
      ##1 !wr1;
  endsequence
  sequence s_hw_rise;
    $rose(hw_trigger_in) && hw_q && !busy_q && chan_q != 5'h1f;
  endsequence
  a_write_starts: assert property (
    wr1 && !hw_q && regWdata[4:0] != 5'h1f
    |=> convStart && convChannel == $past(regWdata[4:0]))
    else $error("no start after write");
  a_off_quiet: assert property (
    wr1 && regWdata[4:0] == 5'h1f
    |=> !convStart ##1 (inputIsolate && !converterOn))
    else $error("off code not honoured");
  a_start_cause: assert property (
    convStart |-> ($past(regWrite) && $past(regAddr) == 3'h0)
    || cont_q || hw_q) else $error("start without cause");
  a_cont_restart: assert property (s_cont_done |-> ##1 convStart)
    else $error("no continuous restart");
  a_hw_start: assert property (s_hw_rise |-> ##[1:8] convStart)
    else $error("trigger ignored");
  a_irq_cause: assert property (
    $rose(doneIrq) |-> $past(coreDone) && ien_q)
    else $error("irq without done");
  a_done_irq: assert property (
    coreDone && busy_q && ien_q && !cmp_q && !wr1 |=> doneIrq)
    else $error("done did not flag");
  a_irq_clear: assert property (wr1 |=> !doneIrq)
    else $error("write left flag set");
endmodule // adc_conversion_control_properties
bind adc_conversion_control adc_conversion_control_properties u_props (
  .clk, .reset, .regAddr, .regWdata, .regWrite, .hw_trigger_in,
  .convStart, .convChannel, .converterOn, .inputIsolate, .coreDone,
  .doneIrq);

// file: testbench/adc_conversion_control_bench.sv
// Self-checking bench for the conversion control block
`timescale 1ns/1ps
module adc_conversion_control_bench;
  reg clk = 0, reset = 1, regWrite = 0, regRead = 0, hw_trigger_in = 0;
  reg [2:0] regAddr = 3'h0;
  reg [7:0] regWdata = 8'h00, q;
  reg [9:0] sample = 10'h000, r, m, cv = 10'h180;
  reg [3:0] lat = 4'h2;
  reg hit, st, ab;
  reg [4:0] chn;
  wire [7:0] regRdata;
  wire [4:0] convChannel;
  wire [9:0] coreResult;
  wire convStart, convAbort, converterOn, inputIsolate;
  wire tenBitMode, coreDone, doneIrq;
  integer n_mismatch = 0, compares = 0, seed = 36, i, n;
  adc_conversion_control u_dut (.clk, .reset, .regAddr, .regWdata,
    .regWrite, .regRead, .regRdata, .hw_trigger_in, .convStart,
    .convChannel, .convAbort, .converterOn, .inputIsolate, .tenBitMode,
    .coreDone, .coreResult, .doneIrq);
  adc_core_model u_core (.clk, .convStart, .convAbort, .sample, .lat,
    .coreDone, .coreResult);
  initial begin
    forever #4 clk = ~clk;
  end
  initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    stop_test;
  end
  ////////////////////////////////////////////////////////////////////////
  task tick;
    begin
      @(posedge clk);
      #1;
    end
  endtask
  task chk(input [9:0] got, input [9:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // Trailing idle cycle keeps strobes from being reassigned at once
  task wr(input [2:0] a, input [7:0] d);
    begin
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      tick;
      st = convStart;
      ab = convAbort;
      chn = convChannel;
      regWrite <= 1'b0;
      tick;
    end
  endtask
  task rdr(input [2:0] a);
    begin
      regAddr <= a;
      regRead <= 1'b1;
      tick;
      regRead <= 1'b0;
      q = regRdata;
      tick;
    end
  endtask
  task waitDone;
    begin
      for (n = 0; n < 40 && coreDone !== 1'b1; n = n + 1) tick;
      chk(coreDone, 1'b1);
      tick;
    end
  endtask
  task count(input integer k);
    begin
      n = 0;
      repeat (k) begin
        tick;
        if (convStart === 1'b1) n = n + 1;
      end
    end
  endtask
  task stop_test;
    begin
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    tick;
    rdr(3'h0);
    chk(q, 8'h1f);
    rdr(3'h1);
    chk(q, 8'h00);
    rdr(3'h7);
    chk(q, 8'h00);
    chk(inputIsolate, 1'b1);
    wr(3'h6, 8'h08);
    for (i = 0; i < 31; i = i + 1) if (i != 28) begin
      r = $random(seed);
      sample <= r;
      lat <= 4'h2 + i[2:0];
      wr(3'h0, {3'b010, i[4:0]});
      chk(st, 1'b1);
      chk(chn, i[4:0]);
      chk(ab, 1'b0);
      rdr(3'h1);
      chk(q[7], 1'b1);
      waitDone;
      chk(doneIrq, 1'b1);
      rdr(3'h0);
      chk(q, {3'b110, i[4:0]});
      rdr(3'h1);
      chk(q[7], 1'b0);
      rdr(3'h2);
      chk(q, r[9:8]);
      rdr(3'h3);
      chk(q, r[7:0]);
      chk(doneIrq, 1'b0);
    end
    wr(3'h4, {6'h00, cv[9:8]});
    wr(3'h5, cv[7:0]);
    for (i = 0; i < 8; i = i + 1) begin
      r = $random(seed);
      sample <= r;
      m = i[1] ? 10'h3ff : 10'h0ff;
      hit = i[0] ? (r & m) >= (cv & m) : (r & m) < (cv & m);
      wr(3'h6, {4'h0, i[1], 3'h0});
      chk(tenBitMode, i[1]);
      wr(3'h1, {2'b00, 1'b1, i[0], 4'h0});
      wr(3'h0, 8'h43);
      waitDone;
      chk(doneIrq, hit);
      rdr(3'h0);
      chk(q[7], hit);
      if (hit) begin
        rdr(3'h2);
        chk(q, r[9:8] & m[9:8]);
        rdr(3'h3);
        chk(q, r[7:0]);
      end
    end
    lat <= 4'h2;
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h25);
    count(40);
    chk(n > 4, 1'b1);
    wr(3'h0, 8'h1f);
    chk(st, 1'b0);
    count(20);
    chk(n, 0);
    chk({inputIsolate, converterOn}, 2'b10);
    wr(3'h0, 8'h47);
    wr(3'h0, 8'h47);
    chk({ab, st}, 2'b11);
    waitDone;
    rdr(3'h3);
    wr(3'h1, 8'h40);
    for (i = 0; i < 3; i = i + 1) begin
      r = $random(seed);
      sample <= r;
      hw_trigger_in <= 1'b1;
      for (n = 0; n < 12 && convStart !== 1'b1; n = n + 1) tick;
      chk(convStart, 1'b1);
      hw_trigger_in <= 1'b0;
      waitDone;
      chk(doneIrq, 1'b1);
      rdr(3'h3);
      chk(q, r[7:0]);
    end
    stop_test;
  end
endmodule // adc_conversion_control_bench
